/* rtl/vta_pkg.sv */
package vta_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_MISC_CTRL   = 8'h03;
  localparam logic [7:0] IDX_SHARED_PINS = 8'h0f;
  localparam logic [7:0] IDX_STOP_HIGH   = 8'h13;
  localparam logic [7:0] IDX_STOP_LOW    = 8'h14;
  localparam logic [7:0] IDX_GENLOCK     = 8'h15;
  localparam logic [7:0] IDX_HSYNC_START = 8'h16;
  localparam logic [7:0] IDX_VERT_BLANK_START  = 8'h18;
  localparam logic [7:0] IDX_VERT_BLANK_STOP   = 8'h19;
  localparam logic [7:0] IDX_CHROMA_ONE  = 8'h1a;
  localparam logic [7:0] IDX_STATUS      = 8'h30;

  // Reset values
  localparam logic [7:0] RST_MISC_CTRL   = 8'h00;
  localparam logic [7:0] RST_SHARED_PINS = 8'h00;
  localparam logic [7:0] RST_STOP_HIGH   = 8'h00;
  localparam logic [1:0] RST_STOP_LOW    = 2'h0;
  localparam logic [7:0] RST_GENLOCK     = 8'h01;
  localparam logic [7:0] RST_HSYNC_START = 8'h80;
  localparam logic [7:0] RST_VERT_BLANK_START  = 8'h00;
  localparam logic [7:0] RST_VERT_BLANK_STOP   = 8'h00;
  localparam logic [7:0] RST_CHROMA_ONE  = 8'h0c;

  // Field positions
  localparam int MISC_VERTICAL_BLANK_OUT_SEL_BIT  = 7;
  localparam int MISC_GP_LATCH_BIT  = 6;
  localparam int PINS_SHARED_SEL    = 1;
  localparam int GL_FV_LSB          = 4;
  localparam int GL_RTC_MODE_BIT    = 2;
  localparam int GL_RTC_SEL_BIT     = 0;
  localparam int CH_PLL_RESET_BIT   = 4;
  localparam int CH_ADAPTIVE_BIT    = 3;
  localparam int CH_COMB_BIT        = 2;
  localparam int CH_AUTO_COLOR_GAIN_CTL_LSB        = 0;

  // Horizontal sync step and neutral code
  localparam int          HSYNC_STEP_CLKS = 4;
  localparam logic [7:0]  HSYNC_NEUTRAL   = 8'h80;

  // Nominal delays in sample clocks
  localparam logic [12:0] NTSC_HB_TO_HS = 13'h001c;
  localparam logic [12:0] NTSC_HB_LEN   = 13'h0110;
  localparam logic [12:0] PAL_HB_TO_HS  = 13'h0020;
  localparam logic [12:0] PAL_HB_LEN    = 13'h011c;

  // Standard frame lengths in lines
  localparam logic [10:0] NTSC_LINES = 11'h20d;
  localparam logic [10:0] PAL_LINES  = 11'h271;

  typedef enum logic [1:0] {
    FV_AUTO   = 2'b00,
    FV_TOGGLE = 2'b01,
    FV_PULSE  = 2'b10,
    FV_ILLEGAL = 2'b11
  } vta_fv_mode_t;

  typedef enum logic [1:0] {
    GL_GENLOCK = 2'b00,
    GL_RTC0    = 2'b01,
    GL_RTC1    = 2'b10
  } vta_gl_mode_t;

  typedef enum logic [1:0] {
    ACG_ON     = 2'b00,
    ACG_RSVD   = 2'b01,
    ACG_OFF    = 2'b10,
    ACG_FROZEN = 2'b11
  } vta_acg_t;
endpackage : vta_pkg

/* rtl/vta_video_timing_adjust.sv */
`timescale 1ns/1ps
// Function
// [RL1] Software keeps active window pixel count even
// [RL2] Stop value commits only on low write
// [RL3] Stop offset ten-bit signed, reset zero
// [RL4] Stop offset moves end-of-active code
// [RL5] Two-bit field flag mode for nonstandard
// [RL6] Vertical flag switches at field boundary
// [RL7] Bits two and zero pick genlock mode
// [RL8] Sync start moves in four-clock steps
// [RL9] Nominal sync and blank delays per standard
// [RL10] Signed vertical blank start line offset
// [RL11] Signed vertical blank stop line offset
// [RL12] Adjusted blank drives shared blank output
// [RL13] Adjusted blank bounds luminance bypass
// [RL14] PLL reset, flag sent next line; genlock_serial_out sends it in genlock mode only, never in RTC modes
// [RL15] Adaptive comb enable, reset enabled
// [RL16] Comb filter enable, reset enabled
// [RL17] Colour gain field: on, off, frozen
// [RL18] Software writes high stop byte first
// [RL19] Stop offset relative to default stop
// [RL20] Shared pin picks latch or blank
// [RL21] Staged high byte commits with low
module vta_video_timing_adjust #(
  parameter int          ADDR_W     = 8,
  parameter logic [12:0] LINE_CLKS  = 13'h06b4,
  parameter logic [12:0] STOP_DFLT  = 13'h06b0,
  parameter logic [12:0] HSYNC_CLKS = 13'h0040,
  parameter logic [10:0] VBI_LINES  = 11'h014
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              video_std_pal,
  input  wire logic [10:0]       frame_lines,
  input  wire logic              intreq_in,
  output logic                   active_video_window,
  output logic                   eav_strobe,
  output logic                   hsync_out,
  output logic                   field_flag,
  output logic                   vert_flag,
  output logic                   vertical_blank_out,
  output logic                   luma_bypass_active,
  output logic                   shared_irq_pin,
  output logic                   general_purpose_latch_out,
  output logic                   genlock_serial_out,
  output logic [1:0]             genlock_mode,
  output logic                   color_pll_reset,
  output logic                   adaptive_comb_enable,
  output logic                   comb_enable,
  output logic [1:0]             auto_color_gain_ctl
);

  // Signed offset helpers
  function automatic logic signed [12:0] sext8(input logic [7:0] v);
    sext8 = {{5{v[7]}}, v};
  endfunction

  function automatic logic in_window(input logic signed [12:0] p,
                                     input logic signed [12:0] lo,
                                     input logic signed [12:0] hi);
    in_window = (p >= lo) && (p < hi);
  endfunction

  // Folds a position into one line; two steps each way cover the widest
  // sync shift and stop offset even on a shortened line
  function automatic logic signed [12:0] wrap_line(
    input logic signed [12:0] d);
    logic signed [12:0] w;
    w = d;
    if (w < 0) begin
      w = w + signed'(LINE_CLKS);
    end
    if (w < 0) begin
      w = w + signed'(LINE_CLKS);
    end
    if (w >= signed'(LINE_CLKS)) begin
      w = w - signed'(LINE_CLKS);
    end
    if (w >= signed'(LINE_CLKS)) begin
      w = w - signed'(LINE_CLKS);
    end
    return w;
  endfunction

  // Register bus decode
  logic [7:0] reg_idx;
  wire        setup_ph = psel & ~penable;
  wire        wr_en    = psel & penable & pready & pwrite & pstrb[0];
  assign reg_idx = 8'(paddr[ADDR_W-1:2]);

  logic [7:0] misc_q;
  logic [7:0] pins_q;
  logic [7:0] stop_hi_q;
  logic [7:0] gl_q;
  logic [7:0] hs_q;
  logic [7:0] vbs_q;
  logic [7:0] vbe_q;
  logic [7:0] ch_q;
  logic [1:0] stop_lo_q;
  logic [9:0] stop_off_q;

  wire wr_misc  = wr_en && reg_idx == vta_pkg::IDX_MISC_CTRL;
  wire wr_pins  = wr_en && reg_idx == vta_pkg::IDX_SHARED_PINS;
  wire wr_sthi  = wr_en && reg_idx == vta_pkg::IDX_STOP_HIGH;
  wire wr_stlo  = wr_en && reg_idx == vta_pkg::IDX_STOP_LOW;
  wire wr_gl    = wr_en && reg_idx == vta_pkg::IDX_GENLOCK;
  wire wr_hs    = wr_en && reg_idx == vta_pkg::IDX_HSYNC_START;
  wire wr_vbs   = wr_en && reg_idx == vta_pkg::IDX_VERT_BLANK_START;
  wire wr_vbe   = wr_en && reg_idx == vta_pkg::IDX_VERT_BLANK_STOP;
  wire wr_ch    = wr_en && reg_idx == vta_pkg::IDX_CHROMA_ONE;

  // Pin input synchroniser: three stages, change accepted on agreement
  logic std_s1_q;
  logic std_s2_q;
  logic std_s3_q;
  logic std_pal_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      std_s1_q  <= 1'b0;
      std_s2_q  <= 1'b0;
      std_s3_q  <= 1'b0;
      std_pal_q <= 1'b0;
    end else begin
      std_s1_q <= video_std_pal;
      std_s2_q <= std_s1_q;
      std_s3_q <= std_s2_q;
      // Stage three only confirms; a value seen in one stage alone
      // never switches the standard
      if (std_s2_q == std_s3_q) begin
        std_pal_q <= std_s3_q;
      end
    end
  end

  // Timing engine state
  logic [12:0] hc_q;
  logic [10:0] line_q;
  logic        pll_pend_q;
  logic        odd_tog_q;
  wire         line_end  = (hc_q == LINE_CLKS - 13'h0001);
  wire         line_start = (hc_q == 13'h0000);

  logic pll_pend_d;
  assign pll_pend_d = (pll_pend_q & ~line_start) |
                      (wr_ch & pwdata[vta_pkg::CH_PLL_RESET_BIT]);

  // Register file
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      misc_q     <= vta_pkg::RST_MISC_CTRL;
      pins_q     <= vta_pkg::RST_SHARED_PINS;
      stop_hi_q  <= vta_pkg::RST_STOP_HIGH;
      stop_lo_q  <= vta_pkg::RST_STOP_LOW;
      stop_off_q <= 10'h000;
      gl_q       <= vta_pkg::RST_GENLOCK;
      hs_q       <= vta_pkg::RST_HSYNC_START;
      vbs_q      <= vta_pkg::RST_VERT_BLANK_START;
      vbe_q      <= vta_pkg::RST_VERT_BLANK_STOP;
      ch_q       <= vta_pkg::RST_CHROMA_ONE;
      pll_pend_q <= 1'b0;
    end else begin
      if (wr_misc) misc_q <= pwdata[7:0];
      if (wr_pins) pins_q <= pwdata[7:0];
      // [RL21] Staged high byte
      if (wr_sthi) stop_hi_q <= pwdata[7:0];
      // [RL2] Commit on low write
      if (wr_stlo) begin
        // A low write alone recommits the old staged byte
        stop_lo_q  <= pwdata[1:0];
        // [RL3] Ten-bit signed join
        stop_off_q <= {stop_hi_q, pwdata[1:0]};
      end
      if (wr_gl) gl_q <= pwdata[7:0];
      if (wr_hs) hs_q <= pwdata[7:0];
      if (wr_vbs) vbs_q <= pwdata[7:0];
      if (wr_vbe) vbe_q <= pwdata[7:0];
      // PLL reset bit is a command and does not stay set
      if (wr_ch) ch_q <= pwdata[7:0] & ~8'h10;
      // [RL14] Pending flag, set wins
      pll_pend_q <= pll_pend_d;
    end
  end

  // Line and pixel counters
  logic        is_std, half_hit;
  logic [10:0] half_lines;
  assign half_lines = frame_lines >> 1;
  assign is_std   = frame_lines == (std_pal_q ? vta_pkg::PAL_LINES
                                              : vta_pkg::NTSC_LINES);
  assign half_hit = line_end && (line_q == half_lines - 11'h001);
  // The >= catches a frame length cut short while the count is past it
  wire   frame_hit = line_end && (line_q >= frame_lines - 11'h001);
  wire   field_hit = half_hit | frame_hit;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hc_q      <= 13'h0000;
      line_q    <= 11'h000;
      odd_tog_q <= 1'b0;
    end else begin
      hc_q <= line_end ? 13'h0000 : hc_q + 13'h0001;
      if (frame_hit) begin
        line_q <= 11'h000;
      end else if (line_end) begin
        line_q <= line_q + 11'h001;
      end
      if (field_hit) odd_tog_q <= ~odd_tog_q;
    end
  end

  // Horizontal positions
  logic [12:0] hb_to_hs, hb_len;
  // [RL9] Nominal delays per standard
  assign hb_to_hs = std_pal_q ? vta_pkg::PAL_HB_TO_HS : vta_pkg::NTSC_HB_TO_HS;
  assign hb_len   = std_pal_q ? vta_pkg::PAL_HB_LEN   : vta_pkg::NTSC_HB_LEN;

  logic signed [12:0] stop_pos, hs_pos, hs_rel, hc_s;
  assign hc_s = signed'(hc_q);
  // [RL19] Relative to default stop
  assign stop_pos = wrap_line(signed'(STOP_DFLT) +
                              signed'({{3{stop_off_q[9]}}, stop_off_q}));
  // [RL8] Four-clock steps around neutral
  assign hs_pos = signed'(hb_to_hs) +
    13'(signed'(signed'({5'h00, vta_pkg::HSYNC_NEUTRAL}) -
                signed'({5'h00, hs_q}))
        * vta_pkg::HSYNC_STEP_CLKS);
  // Codes far from neutral push sync outside the line; fold it back
  assign hs_rel = wrap_line(hc_s - hs_pos);

  logic active_d, eav_d, hsync_d;
  assign active_d = in_window(hc_s, signed'(hb_len), stop_pos);
  // [RL4] End code follows stop offset
  assign eav_d    = hc_s == stop_pos;
  assign hsync_d  = in_window(hs_rel, 13'sh0000, signed'(HSYNC_CLKS));

  // Vertical positions, measured from the current field start
  logic signed [12:0] fl;
  logic signed [12:0] fl_wrap;
  logic signed [12:0] vb_lo;
  logic signed [12:0] vb_hi;
  assign fl      = signed'({2'b00, (line_q >= half_lines)
                                   ? line_q - half_lines : line_q});
  // A negative start reaches into the previous field, so the window is
  // also tested one field back
  assign fl_wrap = fl - signed'({2'b00, half_lines});
  // [RL10] Start offset signed
  assign vb_lo = sext8(vbs_q);
  // [RL11] Stop offset signed
  assign vb_hi = signed'({2'b00, VBI_LINES}) + sext8(vbe_q);

  logic vblank_d, std_vb_d;
  assign vblank_d = in_window(fl, vb_lo, vb_hi) ||
                    in_window(fl_wrap, vb_lo, vb_hi);
  assign std_vb_d = in_window(fl, 13'sh0000, signed'({2'b00, VBI_LINES}));

  // Field flag by mode
  logic field_d;
  logic [1:0] fv_mode;
  assign fv_mode = gl_q[vta_pkg::GL_FV_LSB +: 2];
  always_comb begin
    field_d = line_q >= half_lines;
    // [RL5] Nonstandard field flag modes
    if (!is_std) begin
      case (fv_mode)
        vta_pkg::FV_AUTO:   field_d = frame_lines[0] ? odd_tog_q : 1'b1;
        vta_pkg::FV_TOGGLE: field_d = odd_tog_q;
        vta_pkg::FV_PULSE:  field_d = (fl == 13'sh0000);
        // The illegal code toggles rather than freezing the flag
        default:            field_d = odd_tog_q;
      endcase
    end
  end

  // [RL7] Bit one ignored
  logic [1:0] gl_mode_d;
  assign gl_mode_d = !gl_q[vta_pkg::GL_RTC_SEL_BIT] ? vta_pkg::GL_GENLOCK :
                     gl_q[vta_pkg::GL_RTC_MODE_BIT] ? vta_pkg::GL_RTC1
                                                    : vta_pkg::GL_RTC0;

  // [RL12] Blank or latch on shared pin
  logic blank_pin_d;
  assign blank_pin_d = misc_q[vta_pkg::MISC_VERTICAL_BLANK_OUT_SEL_BIT] ? vblank_d
                     : misc_q[vta_pkg::MISC_GP_LATCH_BIT];

  // Read mux
  // Reads have no side effect; the status byte is a live view
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (reg_idx)
      vta_pkg::IDX_MISC_CTRL:   rd_byte = misc_q;
      vta_pkg::IDX_SHARED_PINS: rd_byte = pins_q;
      vta_pkg::IDX_STOP_HIGH:   rd_byte = stop_hi_q;
      vta_pkg::IDX_STOP_LOW:    rd_byte = {6'h00, stop_lo_q};
      vta_pkg::IDX_GENLOCK:     rd_byte = gl_q;
      vta_pkg::IDX_HSYNC_START: rd_byte = hs_q;
      vta_pkg::IDX_VERT_BLANK_START:  rd_byte = vbs_q;
      vta_pkg::IDX_VERT_BLANK_STOP:   rd_byte = vbe_q;
      vta_pkg::IDX_CHROMA_ONE:  rd_byte = ch_q;
      vta_pkg::IDX_STATUS:      rd_byte = {3'h0, is_std, pll_pend_q,
                                           vblank_d, std_vb_d, field_d};
      default:                  rd_hit  = 1'b0;
    endcase
  end

  // Bus answer: every access completes one cycle after setup
  // An unmapped index still completes, flagged by pslverr, so a host
  // can never stall the bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~rd_hit;
      if (setup_ph && !pwrite) begin
        prdata <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // Registered outputs
  // Every output leaves a flop so no decode glitch reaches a pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_video_window       <= 1'b0;
      eav_strobe                <= 1'b0;
      hsync_out                 <= 1'b0;
      field_flag                <= 1'b0;
      vert_flag                 <= 1'b0;
      vertical_blank_out        <= 1'b0;
      luma_bypass_active        <= 1'b0;
      shared_irq_pin            <= 1'b0;
      general_purpose_latch_out <= 1'b0;
      genlock_serial_out        <= 1'b0;
      genlock_mode              <= vta_pkg::GL_RTC0;
      color_pll_reset           <= 1'b0;
      adaptive_comb_enable      <= 1'b1;
      comb_enable               <= 1'b1;
      auto_color_gain_ctl       <= vta_pkg::ACG_ON;
    end else begin
      active_video_window <= active_d;
      eav_strobe          <= eav_d;
      hsync_out           <= hsync_d;
      field_flag          <= field_d;
      // [RL6] Vertical flag from field start
      vert_flag           <= std_vb_d;
      vertical_blank_out  <= vblank_d;
      // [RL13] Bypass bounded by blank
      luma_bypass_active  <= vblank_d;
      // [RL20] Shared pin select
      shared_irq_pin <= pins_q[vta_pkg::PINS_SHARED_SEL] ? blank_pin_d
                                                         : intreq_in;
      general_purpose_latch_out <= misc_q[vta_pkg::MISC_GP_LATCH_BIT];
      // [RL14] Phase zeroed, flag next line in genlock mode only
      color_pll_reset    <= wr_ch & pwdata[vta_pkg::CH_PLL_RESET_BIT];
      genlock_serial_out <= pll_pend_q & line_start &
                            (gl_mode_d == vta_pkg::GL_GENLOCK);
      genlock_mode       <= gl_mode_d;
      // [RL15] Adaptive comb enable
      adaptive_comb_enable <= ch_q[vta_pkg::CH_ADAPTIVE_BIT];
      // [RL16] Comb enable
      comb_enable          <= ch_q[vta_pkg::CH_COMB_BIT];
      // [RL17] Colour gain field
      auto_color_gain_ctl  <= ch_q[vta_pkg::CH_AUTO_COLOR_GAIN_CTL_LSB +: 2];
    end
  end

endmodule // vta_video_timing_adjust

/* tb/vta_apb_host.sv */
`timescale 1ns/1ps
module vta_apb_host (
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // One transfer; waits for pready however long the slave takes
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the last value
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // vta_apb_host

/* tb/vta_properties.sv */
`timescale 1ns/1ps
module vta_properties #(
  parameter int ADDR_W = 8
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              active_video_window,
  input wire logic              eav_strobe,
  input wire logic              vertical_blank_out,
  input wire logic              luma_bypass_active,
  input wire logic              color_pll_reset,
  input wire logic [1:0]        genlock_mode,
  input wire logic              adaptive_comb_enable,
  input wire logic              comb_enable,
  input wire logic [1:0]        auto_color_gain_ctl
);
  logic       [1:0] gl_q;
  logic       [3:0] ch_q;
  wire  logic [5:0] idx = paddr[7:2];
  wire  logic       wr = psel && penable && pready && pwrite && pstrb[0];
  wire  logic       mapped = idx inside {6'h03, 6'h0f, 6'h13, 6'h14, 6'h15,
                                         6'h16, 6'h18, 6'h19, 6'h1a, 6'h30};

  // Expected mode and chroma fields, captured at the committing edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gl_q <= 2'b01;
      ch_q <= 4'hc;
    end else if (wr && idx == 6'h15) begin
      gl_q <= pwdata[0] ? {pwdata[2], ~pwdata[2]} : 2'b00;
    end else if (wr && idx == 6'h1a) begin
      ch_q <= pwdata[3:0];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("no error on unmapped access");
  eav_single_a: assert property (eav_strobe |=> !eav_strobe)
    else $error("end code strobe too long");
  eav_window_a: assert property (eav_strobe |-> !active_video_window)
    else $error("end code inside active window");
  pll_pulse_a: assert property (
    wr && idx == 6'h1a && pwdata[4] |-> ##[1:2] color_pll_reset)
    else $error("pll reset pulse missing");
  pll_single_a: assert property (color_pll_reset |=> !color_pll_reset)
    else $error("pll reset pulse too long");
  gl_mode_a: assert property (
    wr && idx == 6'h15 |-> ##[1:2] genlock_mode == gl_q)
    else $error("genlock mode wrong");
  gl_no_rsvd_a: assert property (genlock_mode != 2'b11)
    else $error("reserved genlock mode");
  chroma_out_a: assert property (
    wr && idx == 6'h1a |-> ##[1:2] {adaptive_comb_enable, comb_enable,
                                    auto_color_gain_ctl} == ch_q)
    else $error("chroma controls wrong");
  blank_bypass_a: assert property (
    vertical_blank_out == luma_bypass_active)
    else $error("bypass differs from blank");
endmodule // vta_properties

bind vta_video_timing_adjust vta_properties #(.ADDR_W(ADDR_W)) u_vta_properties (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr),
  .active_video_window(active_video_window), .eav_strobe(eav_strobe),
  .vertical_blank_out(vertical_blank_out),
  .luma_bypass_active(luma_bypass_active),
  .color_pll_reset(color_pll_reset), .genlock_mode(genlock_mode),
  .adaptive_comb_enable(adaptive_comb_enable), .comb_enable(comb_enable),
  .auto_color_gain_ctl(auto_color_gain_ctl));

/* tb/vta_video_timing_adjust_tb.sv */
`timescale 1ns/1ps
module vta_video_timing_adjust_tb;
  localparam int L  = 400;
  localparam int SD = 390;
  localparam logic [5:0] ri [6] = '{6'h14, 6'h15, 6'h16, 6'h18, 6'h19, 6'h1a};
  localparam logic [7:0] rv [6] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'h00, 8'h0c};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, q;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pal = 1'b0;
  logic        intreq = 1'b0;
  logic [10:0] fln = 11'h009;
  logic        avw, eav, hs, ff, vf, vb, lb, irq, gpl, gso, pllr, ace, ce, e;
  logic [1:0]  glm, acg;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] rs = 32'd75458;

  always #25 ref_clk = ~ref_clk;

  vta_video_timing_adjust #(.LINE_CLKS(13'h0190), .STOP_DFLT(13'h0186),
    .HSYNC_CLKS(13'h0008), .VBI_LINES(11'h002)) u_vta_video_timing_adjust (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .video_std_pal(pal), .frame_lines(fln), .intreq_in(intreq),
    .active_video_window(avw), .eav_strobe(eav), .hsync_out(hs),
    .field_flag(ff), .vert_flag(vf), .vertical_blank_out(vb),
    .luma_bypass_active(lb), .shared_irq_pin(irq),
    .general_purpose_latch_out(gpl), .genlock_serial_out(gso),
    .genlock_mode(glm), .color_pll_reset(pllr),
    .adaptive_comb_enable(ace), .comb_enable(ce),
    .auto_color_gain_ctl(acg));

  vta_apb_host u_vta_apb_host (
    .ref_clk(ref_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [1:0] exp_gl(logic [7:0] d);
    return d[0] ? (d[2] ? 2'b10 : 2'b01) : 2'b00;
  endfunction

  // Cycles from sync rise to end code: stop position minus sync position
  function automatic int exp_dist(int off, logic [7:0] c, logic p);
    int hp;
    hp = int'(p ? vta_pkg::PAL_HB_TO_HS : vta_pkg::NTSC_HB_TO_HS);
    hp = hp + (128 - int'(c)) * vta_pkg::HSYNC_STEP_CLKS;
    return ((SD + off - hp) % L + 2 * L) % L;
  endfunction

  task automatic summarize();
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(logic w, logic [5:0] i, logic [7:0] d, logic [3:0] s);
    u_vta_apb_host.xfer(w, i, d, s, q, e);
  endtask

  task automatic wt(int s, int lim, output int ok);
    ok = 0;
    for (int n = 0; n < lim && ok == 0; n++) begin
      @(posedge ref_clk);
      ok = (((s == 0) ? pllr : gso) === 1'b1);
    end
  endtask

  task automatic meas(int off, logic [7:0] c);
    int d;
    acc(1, 6'h16, c, 4'hf);
    repeat (L) @(posedge ref_clk);
    while (hs !== 1'b0) @(posedge ref_clk);
    while (hs !== 1'b1) @(posedge ref_clk);
    d = 0;
    while (eav !== 1'b1 && d < 2 * L) begin
      @(posedge ref_clk);
      d++;
    end
    check("dist", d, exp_dist(off, c, pal));
  endtask

  // Counts flag changes over one frame of n lines in a field mode
  task automatic fv(logic [1:0] md, int n, int xf, int xv);
    int cf, cv;
    logic pf, pv;
    fln <= 11'(n);
    acc(1, 6'h15, {2'b00, md, 4'h1}, 4'hf);
    repeat (n * L) @(posedge ref_clk);
    cf = 0;
    cv = 0;
    pf = ff;
    pv = vf;
    repeat (n * L) begin
      @(posedge ref_clk);
      cf += int'(ff !== pf);
      cv += int'(vf !== pv);
      pf = ff;
      pv = vf;
    end
    check("fchg", cf, xf);
    check("vchg", cv, xv);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    int m;
    int off;
    logic [7:0] d;
    logic [31:0] r;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      acc(0, ri[i], 8'h00, 4'h0);
      check("reset", q, rv[i]);
    end
    check("outs", {glm, ace, ce, acg}, 6'h1c);
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      d = {2'b00, k[1:0], 1'b0, k[2], r[0], k[3]};
      acc(1, 6'h15, d, 4'hf);
      acc(1, 6'h1a, {4'h0, k[3:0]}, 4'hf);
      acc(0, 6'h15, 8'h00, 4'h0);
      check("gl", q, d & 8'h37);
      check("glm", glm, exp_gl(d));
      check("chroma", {ace, ce, acg}, k[3:0]);
    end
    for (int i = 2; i < 5; i++) begin
      r = rnd();
      acc(1, ri[i], r[7:0], 4'hf);
      acc(0, ri[i], 8'h00, 4'h0);
      check("rw", q, r[7:0]);
    end
    acc(1, 6'h16, 8'h80, 4'hf);
    acc(1, 6'h16, 8'h11, 4'h0);
    acc(1, 6'h2f, 8'h11, 4'hf);
    check("werr", e, 1'b1);
    acc(0, 6'h20, 8'h00, 4'h0);
    check("rerr", {e, q}, 9'h100);
    acc(0, 6'h16, 8'h00, 4'h0);
    check("strb", q, 8'h80);
    acc(1, 6'h13, 8'h00, 4'hf);
    acc(1, 6'h14, 8'h00, 4'hf);
    meas(0, 8'h80);
    // Staged high byte alone leaves the stop where it was
    acc(1, 6'h13, 8'hff, 4'hf);
    meas(0, 8'h80);
    acc(1, 6'h14, 8'h00, 4'hf);
    meas(-4, 8'h80);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      // Even offsets only, high byte first
      off = r[0] ? 4 : -int'(r[14:8]) * 2;
      pal <= r[24];
      acc(1, 6'h13, off[9:2], 4'hf);
      acc(1, 6'h14, {6'h00, off[1:0]}, 4'hf);
      meas(off, r[23:16]);
    end
    fv(2'b00, 10, 0, 4);
    check("fval", ff, 1'b1);
    fv(2'b00, 9, 2, 4);
    fv(2'b01, 9, 2, 4);
    fv(2'b10, 9, 4, 4);
    acc(1, 6'h15, 8'h00, 4'hf);
    acc(1, 6'h1a, 8'h1c, 4'hf);
    wt(0, 4, m);
    check("pll", m, 1);
    wt(1, 2 * L, m);
    check("genlock_serial_out", m, 1);
    acc(0, 6'h1a, 8'h00, 4'h0);
    check("pllrd", q, 8'h0c);
    intreq <= 1'b1;
    acc(1, 6'h0f, 8'h00, 4'hf);
    check("irq", irq, 1'b1);
    intreq <= 1'b0;
    acc(1, 6'h0f, 8'h02, 4'hf);
    acc(1, 6'h03, 8'h40, 4'hf);
    acc(0, 6'h03, 8'h00, 4'h0);
    check("gpl", {irq, gpl}, 2'b11);
    acc(1, 6'h03, 8'h80, 4'hf);
    acc(0, 6'h03, 8'h00, 4'h0);
    check("vertical_blank_out", irq, vb);
    summarize();
  end
endmodule // vta_video_timing_adjust_tb
